// file: cdt_pkg.sv
// package: register map, field layout, timing counts and shared types of the dual counter/timer
package cdt_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the wishbone bus
   localparam logic [7:0] CDT_OFS_FIRST_COUNT_LOW = 8'h00;
   localparam logic [7:0] CDT_OFS_FIRST_COUNT_HIGH = 8'h04;
   localparam logic [7:0] CDT_OFS_SECOND_COUNT_LOW = 8'h08;
   localparam logic [7:0] CDT_OFS_SECOND_COUNT_HIGH = 8'h0C;
   localparam logic [7:0] CDT_OFS_TIMER_CONTROL_STATUS = 8'h10;
   localparam logic [7:0] CDT_OFS_TIMER_MODE_SELECT = 8'h14;
   localparam logic [7:0] CDT_OFS_CLOCK_CONTROL_REG = 8'h18;
   localparam logic [7:0] CDT_OFS_EXT_INPUT_CONFIG = 8'h1C;
   localparam logic [7:0] CDT_OFS_INTERRUPT_ENABLE_REG = 8'h20;
   localparam logic [7:0] CDT_OFS_IRQ_STATUS = 8'h24;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   // timer_control_status
   localparam int CDT_BIT_FIRST_RUN = 0;
   localparam int CDT_BIT_SECOND_RUN = 1;
   localparam int CDT_BIT_FIRST_FLAG = 2;
   localparam int CDT_BIT_SECOND_FLAG = 3;
   // timer_mode_select: per timer 4 bits, mode in [1:0], counter_select, gate enable
   localparam int CDT_POS_FIRST_MODE = 0;
   localparam int CDT_POS_SECOND_MODE = 4;
   localparam int CDT_BIT_COUNTER_SELECT = 2;
   localparam int CDT_BIT_GATE_ENABLE = 3;
   // clock_control_reg
   localparam int CDT_POS_PRESCALE_SELECT = 0;
   localparam int CDT_BIT_FIRST_SYSTEM_CLOCK_SELECT = 2;
   localparam int CDT_BIT_SECOND_SYSTEM_CLOCK_SELECT = 3;
   // ext_input_config, interrupt_enable_reg and irq status: bit 0 first, bit 1 second
   localparam int CDT_BIT_FIRST = 0;
   localparam int CDT_BIT_SECOND = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] CDT_RST_COUNT = 8'h00;
   localparam logic [7:0] CDT_RST_MODE = 8'h00;
   localparam logic [3:0] CDT_RST_CLKCTL = 4'h0;
   localparam logic [1:0] CDT_RST_POL = 2'h0;
   localparam logic [1:0] CDT_RST_MASK = 2'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler divisors
   localparam int CDT_DIV_A = 12;
   localparam int CDT_DIV_B = 4;
   localparam int CDT_DIV_C = 48;
   localparam int CDT_DIV_EXT = 8;

   // prescale_select codes
   typedef enum logic [1:0] {
      CDT_PS_DIV12,
      CDT_PS_DIV4,
      CDT_PS_DIV48,
      CDT_PS_EXT8
   } cdt_presc_t;

   // counting modes
   typedef enum logic [1:0] {
      CDT_MODE13,
      CDT_MODE16,
      CDT_MODE8R,
      CDT_MODESPLIT
   } cdt_mode_t;

   ////////////////////////////////////////////////////////////////////////////////
   // whole state of the top module
   typedef struct packed {
      logic [7:0] lo0;      // first_count_low
      logic [7:0] hi0;      // first_count_high
      logic [7:0] lo1;      // second_count_low
      logic [7:0] hi1;      // second_count_high
      logic run0;           // first_run
      logic run1;           // second_run
      logic flag0;          // first_overflow_flag
      logic flag1;          // second_overflow_flag
      logic [7:0] modeSel;  // timer_mode_select
      logic [3:0] clkCtl;   // clock_control_reg
      logic [1:0] gatePol;  // gate_polarity bits
      logic [1:0] irqMask;  // interrupt_enable_reg
      logic [2:0] evSync0;  // event pin synchroniser plus edge stage
      logic [2:0] evSync1;
      logic [1:0] gtSync0;  // gate input synchroniser
      logic [1:0] gtSync1;
      logic ack;            // wishbone ack
      logic [31:0] dat;     // wishbone read data
      logic irq;            // interrupt output
      logic ovfEvt0;        // overflow event pulses
      logic ovfEvt1;
   } cdt_state_t;

   // advance one count; returns {overflow, high, low}
   function automatic logic [16:0] cdt_advance(input cdt_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      unique case (m)
         CDT_MODE13: cdt_advance = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         CDT_MODE16: cdt_advance = c16;
         CDT_MODE8R: cdt_advance = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         CDT_MODESPLIT: cdt_advance = {c8[8], hi, c8[7:0]};
      endcase
   endfunction

endpackage

// file: cdt_presc_if.sv
// interface: prescale selection and shared prescaled tick between prescaler and timers
interface cdt_presc_if;
   logic [1:0] sel;  // prescale_select
   logic tick;       // one-cycle pulse of the prescaled clock
   modport src (input sel, output tick);
   modport user (output sel, input tick);
endinterface

// file: cdt_prescaler.sv
// module: shared prescaler making system_clock/12, /4, /48 and external clock /8 ticks
module cdt_prescaler
   import cdt_pkg::*;
#(
   parameter int EXT_DIV = CDT_DIV_EXT
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic extClk,
   cdt_presc_if.src presc
);

   // refuse divisors the 3-bit edge counter cannot serve
   if (EXT_DIV < 2 || EXT_DIV > 8) begin : g_bad_div
      $error("cdt_prescaler: EXT_DIV must be 2..8");
   end

   localparam logic [5:0] MOD_TOP = 6'(CDT_DIV_C - 1);
   localparam logic [2:0] EXT_TOP = 3'(EXT_DIV - 1);

   typedef struct packed {
      logic [5:0] cnt;     // free running modulo-48 counter
      logic [1:0] extSync; // external clock synchroniser
      logic extPrev;       // edge stage
      logic [2:0] extCnt;  // external rising edge counter
      logic tick;          // registered tick
   } cdt_presc_state_t;

   cdt_presc_state_t s_q, s_d;

   // true on the last cycle of each period of div within the 48 cycle frame
   function automatic logic last_of(input logic [5:0] c, input int div);
      last_of = ((32'(c) + 1) % div) == 0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic extRise;
      extRise = 1'b0;
      s_d = s_q;
      s_d.cnt = (s_q.cnt == MOD_TOP) ? 6'h00 : s_q.cnt + 6'h01;
      s_d.extSync = {s_q.extSync[0], extClk};
      s_d.extPrev = s_q.extSync[1];
      extRise = s_q.extSync[1] & ~s_q.extPrev;
      if (extRise) begin
         s_d.extCnt = (s_q.extCnt == EXT_TOP) ? 3'h0 : s_q.extCnt + 3'h1;
      end
      // pick the divided source
      unique case (cdt_presc_t'(presc.sel))
         CDT_PS_DIV12: s_d.tick = last_of(s_q.cnt, CDT_DIV_A);
         CDT_PS_DIV4: s_d.tick = last_of(s_q.cnt, CDT_DIV_B);
         CDT_PS_DIV48: s_d.tick = last_of(s_q.cnt, CDT_DIV_C);
         CDT_PS_EXT8: s_d.tick = extRise && (s_q.extCnt == EXT_TOP);
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign presc.tick = s_q.tick;

endmodule

// file: cdt_timer_top.sv
// module: two legacy 16-bit counter/timers with wishbone register access and interrupt
//
// Functional notes
// - 16-bit count per timer, two byte registers
// - four modes; split mode only on first
// - mode 0: high byte plus low bits 4..0
// - 13-bit wrap sets flag, may interrupt
// - per-timer interrupt enable gates overflow request
// - counter select counts event pin falling edges; while first is split the second timer counts internal clock instead
// - events up to clock/4; pin held two cycles
// - system_clock select picks system clock else prescaled
// - prescaler: /12, /4, /48, external /8
// - count only when run (second timer also while first is split), gate adds input
// - polarity bit picks active gate level
// - second timer mirrors first with own controls
// - each timer overflow offered as output event; split high byte overflow is not
// - setting run keeps the loaded count
// - mode 1 counts full 16 bits
// - mode 2 low byte reloads from high
// - split high byte: system_clock, second run, second flag; counts prescaled tick unless first system_clock select is set
module cdt_timer_top
   import cdt_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic firstEventPin,
   input wire logic secondEventPin,
   input wire logic firstGateInput,
   input wire logic secondGateInput,
   input wire logic extClk,
   output logic irq,
   output logic firstOverflowEvt,
   output logic secondOverflowEvt
);

   ////////////////////////////////////////////////////////////////////////////////
   // state and prescaler hookup
   cdt_state_t s_q, s_d;   // complete module state
   cdt_presc_if presc ();  // link to the shared prescaler

   cdt_prescaler #(
      .EXT_DIV(CDT_DIV_EXT)
   ) u_presc (
      .clock(clock),
      .resetn(resetn),
      .extClk(extClk),
      .presc(presc)
   );

   assign presc.sel = s_q.clkCtl[CDT_POS_PRESCALE_SELECT +: 2];

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      cdt_mode_t mode0;
      cdt_mode_t mode1;
      logic fall0;
      logic fall1;
      logic tick0;
      logic tick1;
      logic tickHi;
      logic en0;
      logic en1;
      logic gateOk0;
      logic gateOk1;
      logic [16:0] adv0;
      logic [16:0] adv1;
      logic [8:0] advHi;
      logic ovf0;
      logic ovf1;
      logic set0;
      logic set1;
      logic req;
      logic wr;
      logic [7:0] wb;
      logic [31:0] rd;
      mode0 = cdt_mode_t'(s_q.modeSel[CDT_POS_FIRST_MODE +: 2]);
      mode1 = cdt_mode_t'(s_q.modeSel[CDT_POS_SECOND_MODE +: 2]);
      fall0 = 1'b0;
      fall1 = 1'b0;
      tick0 = 1'b0;
      tick1 = 1'b0;
      tickHi = 1'b0;
      en0 = 1'b0;
      en1 = 1'b0;
      gateOk0 = 1'b0;
      gateOk1 = 1'b0;
      adv0 = '0;
      adv1 = '0;
      advHi = '0;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      set0 = 1'b0;
      set1 = 1'b0;
      req = cyc_i & stb_i;
      wr = req & we_i & s_q.ack & sel_i[0];
      wb = dat_i[7:0];
      rd = '0;
      s_d = s_q;

      // synchronisers: first stage feeds only the second; third stage is the edge detector
      s_d.evSync0 = {s_q.evSync0[1:0], firstEventPin};
      s_d.evSync1 = {s_q.evSync1[1:0], secondEventPin};
      s_d.gtSync0 = {s_q.gtSync0[0], firstGateInput};
      s_d.gtSync1 = {s_q.gtSync1[0], secondGateInput};
      fall0 = s_q.evSync0[2] & ~s_q.evSync0[1];
      fall1 = s_q.evSync1[2] & ~s_q.evSync1[1];

      // gate qualification: active when synced level equals polarity
      gateOk0 = ~s_q.modeSel[CDT_POS_FIRST_MODE + CDT_BIT_GATE_ENABLE]
              | (s_q.gtSync0[1] == s_q.gatePol[CDT_BIT_FIRST]);
      gateOk1 = ~s_q.modeSel[CDT_POS_SECOND_MODE + CDT_BIT_GATE_ENABLE]
              | (s_q.gtSync1[1] == s_q.gatePol[CDT_BIT_SECOND]);
      en0 = s_q.run0 & gateOk0;
      // second timer runs under its own run bit, or by mode alone while first is split
      en1 = (mode0 == CDT_MODESPLIT) ? (mode1 != CDT_MODESPLIT) : (s_q.run1 & gateOk1);

      // source selection per timer
      if (s_q.modeSel[CDT_POS_FIRST_MODE + CDT_BIT_COUNTER_SELECT]) begin
         tick0 = fall0;
      end else if (s_q.clkCtl[CDT_BIT_FIRST_SYSTEM_CLOCK_SELECT]) begin
         tick0 = 1'b1;
      end else begin
         tick0 = presc.tick;
      end
      if (s_q.modeSel[CDT_POS_SECOND_MODE + CDT_BIT_COUNTER_SELECT] && mode0 != CDT_MODESPLIT) begin
         tick1 = fall1;
      end else if (s_q.clkCtl[CDT_BIT_SECOND_SYSTEM_CLOCK_SELECT]) begin
         tick1 = 1'b1;
      end else begin
         tick1 = presc.tick;
      end
      // split high byte counts internal clock only
      tickHi = s_q.clkCtl[CDT_BIT_FIRST_SYSTEM_CLOCK_SELECT] ? 1'b1 : presc.tick;

      // first timer: one step per qualified tick, count left as loaded
      adv0 = cdt_advance(mode0, s_q.hi0, s_q.lo0);
      if (en0 && tick0) begin
         s_d.hi0 = adv0[15:8];
         s_d.lo0 = adv0[7:0];
         ovf0 = adv0[16];
      end
      // split mode: high byte is its own 8-bit timer
      if (mode0 == CDT_MODESPLIT) begin
         advHi = {1'b0, s_q.hi0} + 9'h001;
         s_d.hi0 = s_q.hi0;
         if (s_q.run1 && tickHi) begin
            s_d.hi0 = advHi[7:0];
         end
      end

      // second timer: split mode not offered, it simply stops there
      adv1 = cdt_advance(mode1, s_q.hi1, s_q.lo1);
      if (en1 && tick1 && mode1 != CDT_MODESPLIT) begin
         s_d.hi1 = adv1[15:8];
         s_d.lo1 = adv1[7:0];
         ovf1 = adv1[16];
      end

      // flag sources; while split, only the high byte may raise the second flag
      set0 = ovf0;
      if (mode0 == CDT_MODESPLIT) begin
         set1 = advHi[8] & s_q.run1 & tickHi;
      end else begin
         set1 = ovf1;
      end

      // overflow event outputs, one cycle pulses
      s_d.ovfEvt0 = ovf0;
      s_d.ovfEvt1 = ovf1;

      ////////////////////////////////////////////////////////////////////////////////
      // register writes: taken at the edge where ack is high; software load beats the count
      if (wr) begin
         unique case (adr_i)
            CDT_OFS_FIRST_COUNT_LOW: s_d.lo0 = wb;
            CDT_OFS_FIRST_COUNT_HIGH: s_d.hi0 = wb;
            CDT_OFS_SECOND_COUNT_LOW: s_d.lo1 = wb;
            CDT_OFS_SECOND_COUNT_HIGH: s_d.hi1 = wb;
            CDT_OFS_TIMER_CONTROL_STATUS: begin
               s_d.run0 = wb[CDT_BIT_FIRST_RUN];
               s_d.run1 = wb[CDT_BIT_SECOND_RUN];
            end
            CDT_OFS_TIMER_MODE_SELECT: s_d.modeSel = wb;
            CDT_OFS_CLOCK_CONTROL_REG: s_d.clkCtl = wb[3:0];
            CDT_OFS_EXT_INPUT_CONFIG: s_d.gatePol = wb[1:0];
            CDT_OFS_INTERRUPT_ENABLE_REG: s_d.irqMask = wb[1:0];
            CDT_OFS_IRQ_STATUS: begin
               // write one to clear
               if (wb[CDT_BIT_FIRST]) begin
                  s_d.flag0 = 1'b0;
               end
               if (wb[CDT_BIT_SECOND]) begin
                  s_d.flag1 = 1'b0;
               end
            end
            default: ;                                          // unmapped: ignored
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (set0) begin
         s_d.flag0 = 1'b1;
      end
      if (set1) begin
         s_d.flag1 = 1'b1;
      end

      // interrupt level from enabled flags
      s_d.irq = (s_d.flag0 & s_d.irqMask[CDT_BIT_FIRST])
              | (s_d.flag1 & s_d.irqMask[CDT_BIT_SECOND]);

      ////////////////////////////////////////////////////////////////////////////////
      // read mux; unmapped reads return zero
      unique case (adr_i)
         CDT_OFS_FIRST_COUNT_LOW: rd = {24'h000000, s_q.lo0};
         CDT_OFS_FIRST_COUNT_HIGH: rd = {24'h000000, s_q.hi0};
         CDT_OFS_SECOND_COUNT_LOW: rd = {24'h000000, s_q.lo1};
         CDT_OFS_SECOND_COUNT_HIGH: rd = {24'h000000, s_q.hi1};
         CDT_OFS_TIMER_CONTROL_STATUS: rd = {28'h0000000, s_q.flag1, s_q.flag0, s_q.run1, s_q.run0};
         CDT_OFS_TIMER_MODE_SELECT: rd = {24'h000000, s_q.modeSel};
         CDT_OFS_CLOCK_CONTROL_REG: rd = {28'h0000000, s_q.clkCtl};
         CDT_OFS_EXT_INPUT_CONFIG: rd = {30'h00000000, s_q.gatePol};
         CDT_OFS_INTERRUPT_ENABLE_REG: rd = {30'h00000000, s_q.irqMask};
         CDT_OFS_IRQ_STATUS: rd = {30'h00000000, s_q.flag1, s_q.flag0};
         default: rd = 32'h00000000;
      endcase

      // classic handshake: ack one cycle after the request, dropped the cycle after
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack) begin
         s_d.dat = rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{lo0: CDT_RST_COUNT, hi0: CDT_RST_COUNT, lo1: CDT_RST_COUNT, hi1: CDT_RST_COUNT,
                  modeSel: CDT_RST_MODE, clkCtl: CDT_RST_CLKCTL, gatePol: CDT_RST_POL,
                  irqMask: CDT_RST_MASK, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign dat_o = s_q.dat;
   assign ack_o = s_q.ack;
   assign irq = s_q.irq;
   assign firstOverflowEvt = s_q.ovfEvt0;
   assign secondOverflowEvt = s_q.ovfEvt1;

endmodule

// file: cdt_timer_sva.sv
// checker: concurrent checks on the ports of the dual counter/timer
module cdt_timer_sva
   import cdt_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic irq,
   input wire logic firstOverflowEvt,
   input wire logic secondOverflowEvt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic unmapped; // address outside the register map
   assign unmapped = (adr_i > CDT_OFS_IRQ_STATUS) || (adr_i[1:0] != 2'h0);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // a request that the slave takes
   sequence wbTaken;
      cyc_i && stb_i && !ack_o;
   endsequence
   // one answer, dropped again at once
   sequence ackOnce;
      ack_o ##1 !ack_o;
   endsequence
   // an overflow event pulse, launched at the same edge as the flag it sets
   sequence ovfNow;
      firstOverflowEvt || secondOverflowEvt;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   ack_answer_a: assert property (wbTaken |=> ackOnce)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   unmapped_zero_a: assert property (ack_o && !we_i && unmapped |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
      else $error("read data above the byte not zero");
   irq_rise_a: assert property ($rose(irq) |-> ($past(cyc_i && we_i) || $past(cyc_i && we_i, 2)) or ovfNow)
      else $error("interrupt rose without overflow or write");
   irq_fall_a: assert property ($fell(irq) |-> $past(cyc_i && we_i) || $past(cyc_i && we_i, 2))
      else $error("interrupt fell without a write");
   reset_quiet_a: assert property ($rose(resetn) |-> !ack_o && !irq && !firstOverflowEvt)
      else $error("outputs active right after reset");
   ovf_seen_c: cover property (firstOverflowEvt && secondOverflowEvt);
endmodule
bind cdt_timer_top cdt_timer_sva u_sva (
   .clock(clock), .resetn(resetn), .adr_i(adr_i), .dat_o(dat_o), .we_i(we_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .irq(irq), .firstOverflowEvt(firstOverflowEvt),
   .secondOverflowEvt(secondOverflowEvt)
);

// file: cdt_partner_model.sv
// model of the outside world: event pins, gate levels and the external clock
module cdt_partner_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic evGo,
   input wire logic [3:0] evCount,
   input wire logic gateLvl,
   output logic firstEventPin,
   output logic secondEventPin,
   output logic firstGateInput,
   output logic secondGateInput,
   output logic extClk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left; // events still to send
   logic ph; // which half of a two-cycle hold
   logic [1:0] ec; // external clock divider
   // both pins and both gates follow the same stimulus
   assign secondEventPin = firstEventPin;
   assign firstGateInput = gateLvl;
   assign secondGateInput = gateLvl;
   ////////////////////////////////////////////////////////////////////////////////
   // each level held two full cycles, so one event spans four
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         left <= 4'h0;
         ph <= 1'b0;
         firstEventPin <= 1'b1;
         ec <= 2'h0;
         extClk <= 1'b0;
      end else begin
         ec <= (ec == 2'h2) ? 2'h0 : ec + 2'h1;
         if (ec == 2'h2) begin // free-running clock, period six cycles
            extClk <= ~extClk;
         end
         if (evGo) begin
            left <= evCount;
         end else if (left != 4'h0) begin
            ph <= ~ph;
            if (ph) begin
               firstEventPin <= ~firstEventPin;
               left <= firstEventPin ? left : left - 4'h1;
            end
         end
      end
   end
endmodule

// file: classic_dual_counter_timer_tb_top.sv
// testbench: register access, overflow, event, gate, reload and prescaler cases
module classic_dual_counter_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] adrI = 8'h00;
   logic [31:0] datI = 32'h0;
   logic [3:0] selI = 4'h0;
   logic weI = 1'b0, cycI = 1'b0, stbI = 1'b0, evGo = 1'b0, gateLvl = 1'b0;
   logic [3:0] evCount = 4'h0;
   logic [31:0] datO;
   logic ackO, irq, ovf0, ovf1, ev0, ev1, gt0, gt1, extClk;
   int nMismatch = 0, checked = 0, nOvf0 = 0, nOvf1 = 0;
   // address, write data, read-back
   logic [23:0] rows [12] = '{24'h00A5A5, 24'h045A5A, 24'h08C3C3, 24'h0C3C3C, 24'h100C00, 24'h145A5A,
      24'h18FF0F, 24'h1CFF03, 24'h20FF03, 24'h24FF00, 24'h28FF00, 24'h02FF00};
   int expDiv [4] = '{40, 120, 10, 10}; // counts in 480 cycles per prescale code
   cdt_timer_top dut (.clock(clock), .resetn(resetn), .adr_i(adrI), .dat_i(datI), .dat_o(datO),
      .we_i(weI), .sel_i(selI), .cyc_i(cycI), .stb_i(stbI), .ack_o(ackO), .firstEventPin(ev0),
      .secondEventPin(ev1), .firstGateInput(gt0), .secondGateInput(gt1), .extClk(extClk), .irq(irq),
      .firstOverflowEvt(ovf0), .secondOverflowEvt(ovf1));
   cdt_partner_model partner (.clock(clock), .resetn(resetn), .evGo(evGo), .evCount(evCount),
      .gateLvl(gateLvl), .firstEventPin(ev0), .secondEventPin(ev1), .firstGateInput(gt0),
      .secondGateInput(gt1), .extClk(extClk));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and overflow pulse counters
   initial begin
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      nOvf0 += (ovf0 === 1'b1);
      nOvf1 += (ovf1 === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic results;
      if (nMismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // compare and report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic bus cycle, held until ack, then one idle cycle
   task automatic wbCycle(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      adrI <= a;
      weI <= w;
      datI <= {24'h0, d};
      selI <= 4'h1;
      cycI <= 1'b1;
      stbI <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (ackO !== 1'b1 && n < 20);
      r = datO[7:0];
      cycI <= 1'b0;
      stbI <= 1'b0;
      if (ackO !== 1'b1) begin // no answer at all
         nMismatch++;
         results();
      end
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      wbCycle(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      wbCycle(a, 1'b0, 8'h00, r);
   endtask
   // bounded wait for a new first-timer overflow
   task automatic waitOvf(input int base);
      int n;
      n = 0;
      while (nOvf0 == base && n < 300) begin
         @(posedge clock);
         n++;
      end
      if (nOvf0 == base) begin
         nMismatch++;
         results();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] v;
      int b0, b1;
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 12; i++) begin // reset values
         rd(rows[i][23:16], v);
         check(v, 8'h00);
      end
      for (int i = 0; i < 12; i++) begin // write then read back
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], v);
         check(v, rows[i][7:0]);
      end
      // 16-bit wrap on the system clock
      wr(8'h18, 8'h04);
      wr(8'h14, 8'h01);
      wr(8'h00, 8'hFE);
      wr(8'h04, 8'hFF);
      wr(8'h20, 8'h01);
      b0 = nOvf0;
      b1 = nOvf1;
      wr(8'h10, 8'h01);
      waitOvf(b0);
      wr(8'h10, 8'h00);
      rd(8'h10, v);
      check(v, 8'h04);
      check({7'h0, irq}, 8'h01);
      check(8'(nOvf1 - b1), 8'h00);
      wr(8'h20, 8'h00);
      check({7'h0, irq}, 8'h00);
      wr(8'h20, 8'h01);
      wr(8'h24, 8'h01);
      rd(8'h24, v);
      check(v | {7'h0, irq}, 8'h00);
      // 13-bit counting of pin events on both timers
      wr(8'h18, 8'h00);
      wr(8'h14, 8'h44);
      wr(8'h00, 8'hFD);
      wr(8'h04, 8'hFF);
      wr(8'h08, 8'hFD);
      wr(8'h0C, 8'hFF);
      wr(8'h20, 8'h03);
      b0 = nOvf0;
      b1 = nOvf1;
      wr(8'h10, 8'h03);
      evCount <= 4'h3;
      evGo <= 1'b1;
      @(posedge clock);
      evGo <= 1'b0;
      waitOvf(b0);
      wr(8'h10, 8'h00);
      rd(8'h00, v);
      check(v & 8'h1F, 8'h00);
      rd(8'h04, v);
      check(v, 8'h00);
      rd(8'h08, v);
      check(v & 8'h1F, 8'h00);
      rd(8'h0C, v);
      check(v, 8'h00);
      rd(8'h24, v);
      check(v, 8'h03);
      check(8'(nOvf1 - b1), 8'h01);
      check({7'h0, irq}, 8'h01);
      wr(8'h24, 8'h03);
      // gated counting, gate input held low
      wr(8'h14, 8'h09);
      wr(8'h18, 8'h04);
      wr(8'h1C, 8'h01);
      wr(8'h00, 8'h34);
      wr(8'h04, 8'h12);
      wr(8'h10, 8'h01);
      repeat (20) @(posedge clock);
      rd(8'h00, v);
      check(v, 8'h34);
      wr(8'h1C, 8'h00);
      repeat (20) @(posedge clock);
      rd(8'h00, v);
      check({7'h0, v === 8'h34}, 8'h00);
      wr(8'h10, 8'h00);
      // 8-bit auto-reload
      wr(8'h14, 8'h02);
      wr(8'h04, 8'hF0);
      wr(8'h00, 8'hFE);
      b0 = nOvf0;
      wr(8'h10, 8'h01);
      waitOvf(b0);
      wr(8'h10, 8'h00);
      rd(8'h04, v);
      check(v, 8'hF0);
      rd(8'h00, v);
      check({7'h0, v >= 8'hF0}, 8'h01);
      wr(8'h24, 8'h03);
      // every prescale code over a fixed window
      wr(8'h14, 8'h01);
      wr(8'h04, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(8'h18, 8'(c));
         wr(8'h00, 8'h00);
         wr(8'h10, 8'h01);
         repeat (480) @(posedge clock);
         wr(8'h10, 8'h00);
         rd(8'h00, v);
         check({7'h0, (v + 8'd2 >= 8'(expDiv[c])) && (v <= 8'(expDiv[c] + 2))}, 8'h01);
      end
      // second timer: own gate high-active, own system clock select
      wr(8'h14, 8'h90);
      wr(8'h18, 8'h08);
      wr(8'h1C, 8'h00);
      gateLvl <= 1'b1;
      wr(8'h08, 8'h10);
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h02);
      repeat (20) @(posedge clock);
      rd(8'h08, v);
      check(v, 8'h10);
      wr(8'h1C, 8'h02);
      repeat (20) @(posedge clock);
      wr(8'h10, 8'h00);
      rd(8'h08, v);
      check({7'h0, v === 8'h10}, 8'h00);
      gateLvl <= 1'b0;
      // split mode: high byte runs under the second run bit, second timer off
      wr(8'h20, 8'h00);
      wr(8'h14, 8'h33);
      wr(8'h18, 8'h04);
      wr(8'h00, 8'h00);
      wr(8'h04, 8'hFE);
      b1 = nOvf1;
      wr(8'h10, 8'h02);
      repeat (4) @(posedge clock);
      wr(8'h10, 8'h00);
      rd(8'h24, v);
      check(v, 8'h02);
      rd(8'h00, v);
      check(v, 8'h00);
      check(8'(nOvf1 - b1), 8'h00);
      check({7'h0, irq}, 8'h00);
      results();
   end
endmodule
